// ---- src/cdr_start_value_interval_tol.sv ----
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cdr_start_value_interval_tol (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [cdr_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [cdr_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [cdr_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input wire logic SAMPLE_VALID_IN,
  input wire logic EDGE_IN,
  input wire logic ACQ_START_IN,
  output logic SYNC_FOUND_OUT,
  output logic SYNC_LOST_OUT,
  output logic EDGE_ACCEPT_OUT,
  output logic INTEG_LOAD_OUT,
  output logic [cdr_pkg::EST_W-1:0] INTEG_VALUE_OUT,
  output logic IRQ_OUT
);
  import cdr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // signed offset of an edge from its nearest border, in sixteenths
  function automatic logic signed [PHASE_W:0] border_offset(input logic [PHASE_W-1:0] ph);
    logic [PHASE_W-1:0] rel;
    rel = ph - CHIP_BORDER_PHASE;
    if (ph[PHASE_W-1] == ph[PHASE_W-2])
      border_offset = $signed({ph[PHASE_W-1], ph});
    else
      border_offset = $signed({rel[PHASE_W-1], rel});
  endfunction

  function automatic logic [DATA_W-1:0] masked_write(input logic [DATA_W-1:0] wd,
                                                     input logic [DATA_W-1:0] msk);
    masked_write = wd & msk;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [DATA_W-1:0] start_value_interval_cfg_reg, start_value_interval_cfg_next;
  logic [DATA_W-1:0] chip_tol_reg, chip_tol_next;
  logic [DATA_W-1:0] bit_tol_reg, bit_tol_next;
  logic [DATA_W-1:0] window_reg, window_next;
  logic [DATA_W-1:0] pos_limit_reg, pos_limit_next;
  logic [DATA_W-1:0] neg_limit_reg, neg_limit_next;
  logic [DATA_W-1:0] irq_status_reg, irq_status_next;
  logic [DATA_W-1:0] irq_mask_reg, irq_mask_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [DATA_W-1:0] irq_events;

  cdr_state_e state_reg, state_next;
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic [BITCNT_W-1:0] bitcnt_reg, bitcnt_next;
  logic signed [SUM_W-1:0] err_sum_reg, err_sum_next;
  logic [NOEDGE_W-1:0] noedge_reg, noedge_next;
  logic signed [EST_W-1:0] est_reg, est_next;
  logic found_reg, found_next;
  logic lost_reg, lost_next;
  logic load_reg, load_next;
  logic accept_reg, accept_next;

  logic start_value_interval_limen;
  logic [START_VALUE_INTERVAL_LENGTH_W-1:0] start_value_interval_len;
  logic chip_hit, bit_hit, edge_ok, edge_bad, start_value_interval_done, rate_bad;
  logic [BITCNT_W-1:0] start_value_interval_bits;
  logic signed [SUM_W-1:0] sum_acc, sum_shifted;
  logic signed [EST_W-1:0] est_calc;
  logic [NOEDGE_W-1:0] noedge_inc;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_comb
  begin
    start_value_interval_cfg_next = start_value_interval_cfg_reg;
    chip_tol_next = chip_tol_reg;
    bit_tol_next = bit_tol_reg;
    window_next = window_reg;
    pos_limit_next = pos_limit_reg;
    neg_limit_next = neg_limit_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    rdata_next = '0;
    if (REG_WR_IN)
    begin
      case (REG_ADDR_IN)
        OFF_START_VALUE_INTERVAL_CFG: start_value_interval_cfg_next = masked_write(REG_WDATA_IN, WMASK_START_VALUE_INTERVAL_CFG);
        OFF_CHIP_TOL: chip_tol_next = masked_write(REG_WDATA_IN, WMASK_TOL);
        OFF_BIT_TOL: bit_tol_next = masked_write(REG_WDATA_IN, WMASK_TOL);
        OFF_WINDOW: window_next = masked_write(REG_WDATA_IN, WMASK_WINDOW);
        OFF_POS_LIMIT: pos_limit_next = REG_WDATA_IN;
        OFF_NEG_LIMIT: neg_limit_next = REG_WDATA_IN;
        OFF_IRQ_MASK: irq_mask_next = masked_write(REG_WDATA_IN, WMASK_IRQ);
        OFF_IRQ_STATUS: irq_status_next = irq_status_reg & ~masked_write(REG_WDATA_IN, WMASK_IRQ);
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    irq_status_next = irq_status_next | irq_events;
    if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        OFF_START_VALUE_INTERVAL_CFG: rdata_next = start_value_interval_cfg_reg;
        OFF_CHIP_TOL: rdata_next = chip_tol_reg;
        OFF_BIT_TOL: rdata_next = bit_tol_reg;
        OFF_WINDOW: rdata_next = window_reg;
        OFF_POS_LIMIT: rdata_next = pos_limit_reg;
        OFF_NEG_LIMIT: rdata_next = neg_limit_reg;
        OFF_IRQ_STATUS: rdata_next = irq_status_reg;
        OFF_IRQ_MASK: rdata_next = irq_mask_reg;
        OFF_LOOP_STATE: rdata_next = {{(DATA_W-2){1'b0}}, state_reg};
        OFF_RATE_EST: rdata_next = est_reg[DATA_W-1:0];
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      start_value_interval_cfg_reg <= RST_START_VALUE_INTERVAL_CFG;
      chip_tol_reg <= RST_CHIP_TOL;
      bit_tol_reg <= RST_BIT_TOL;
      window_reg <= RST_WINDOW;
      pos_limit_reg <= RST_POS_LIMIT;
      neg_limit_reg <= RST_NEG_LIMIT;
      irq_status_reg <= '0;
      irq_mask_reg <= RST_IRQ_MASK;
      rdata_reg <= '0;
    end
    else
    begin
      start_value_interval_cfg_reg <= start_value_interval_cfg_next;
      chip_tol_reg <= chip_tol_next;
      bit_tol_reg <= bit_tol_next;
      window_reg <= window_next;
      pos_limit_reg <= pos_limit_next;
      neg_limit_reg <= neg_limit_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA_OUT = rdata_reg;
  assign IRQ_OUT = |(irq_status_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // edge windows around chip and bit borders

  cdr_border_check #(
    .PHASE_W(PHASE_W),
    .TOL_W(TOL_W)
  ) u_chip_check (
    .phase_in(phase_reg),
    .center_in(CHIP_BORDER_PHASE),
    .early_tol_in(chip_tol_reg[TOL_EARLY_LSB +: TOL_W]),
    .late_tol_in(chip_tol_reg[TOL_LATE_LSB +: TOL_W]),
    .hit_out(chip_hit)
  );

  cdr_border_check #(
    .PHASE_W(PHASE_W),
    .TOL_W(TOL_W)
  ) u_bit_check (
    .phase_in(phase_reg),
    .center_in(BIT_BORDER_PHASE),
    .early_tol_in(bit_tol_reg[TOL_EARLY_LSB +: TOL_W]),
    .late_tol_in(bit_tol_reg[TOL_LATE_LSB +: TOL_W]),
    .hit_out(bit_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // recovery loop sequencing

  always_comb
  begin
    start_value_interval_limen = start_value_interval_cfg_reg[LIMEN_BIT];
    start_value_interval_len = start_value_interval_cfg_reg[START_VALUE_INTERVAL_LENGTH_LSB +: START_VALUE_INTERVAL_LENGTH_W];
    start_value_interval_bits = BITCNT_W'(1) << (START_VALUE_INTERVAL_SHIFT_BASE + int'(start_value_interval_len));
    edge_ok = SAMPLE_VALID_IN && EDGE_IN && (chip_hit || bit_hit);
    edge_bad = SAMPLE_VALID_IN && EDGE_IN && !(chip_hit || bit_hit);
    sum_acc = edge_ok ? err_sum_reg + SUM_W'(border_offset(phase_reg)) : err_sum_reg;
    // longer run-in divides a larger sum, averaging out jitter
    sum_shifted = sum_acc >>> (START_VALUE_INTERVAL_SHIFT_BASE + int'(start_value_interval_len));
    est_calc = sum_shifted[EST_W-1:0];
    start_value_interval_done = SAMPLE_VALID_IN && (phase_reg == LAST_PHASE)
                 && (bitcnt_reg == start_value_interval_bits - BITCNT_W'(1));
    rate_bad = start_value_interval_limen
               && ((sum_shifted > $signed({{(SUM_W-DATA_W){1'b0}}, pos_limit_reg}))
                   || (sum_shifted < -$signed({{(SUM_W-DATA_W){1'b0}}, neg_limit_reg})));
    // saturate so a long silence never wraps back into range
    noedge_inc = (noedge_reg == {NOEDGE_W{1'b1}}) ? noedge_reg : noedge_reg + NOEDGE_W'(1);

    state_next = state_reg;
    phase_next = phase_reg;
    bitcnt_next = bitcnt_reg;
    err_sum_next = err_sum_reg;
    noedge_next = noedge_reg;
    est_next = est_reg;
    found_next = 1'b0;
    lost_next = 1'b0;
    load_next = 1'b0;
    accept_next = edge_ok && (state_reg == ST_START_VALUE_INTERVAL || state_reg == ST_TRACK);

    if (SAMPLE_VALID_IN)
    begin
      phase_next = phase_reg + PHASE_W'(1);
      noedge_next = edge_ok ? '0 : noedge_inc;
    end

    case (state_reg)
      ST_IDLE, ST_LOST:
      begin
        noedge_next = '0;
      end
      ST_START_VALUE_INTERVAL:
      begin
        err_sum_next = sum_acc;
        if (SAMPLE_VALID_IN && (phase_reg == LAST_PHASE))
          bitcnt_next = bitcnt_reg + BITCNT_W'(1);
        if (noedge_next > NOEDGE_W'(window_reg))
        begin
          state_next = ST_LOST;
          lost_next = 1'b1;
        end
        else if (start_value_interval_done && rate_bad)
        begin
          // out of range estimate: restart the run-in rather than lock
          bitcnt_next = '0;
          err_sum_next = '0;
        end
        else if (start_value_interval_done)
        begin
          est_next = est_calc;
          load_next = 1'b1;
          found_next = 1'b1;
          state_next = ST_TRACK;
        end
      end
      ST_TRACK:
      begin
        if (noedge_next > NOEDGE_W'(window_reg))
        begin
          state_next = ST_LOST;
          lost_next = 1'b1;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase

    if (ACQ_START_IN)
    begin
      state_next = ST_START_VALUE_INTERVAL;
      phase_next = '0;
      bitcnt_next = '0;
      err_sum_next = '0;
      noedge_next = '0;
      found_next = 1'b0;
      lost_next = 1'b0;
      load_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      bitcnt_reg <= '0;
      err_sum_reg <= '0;
      noedge_reg <= '0;
      est_reg <= '0;
      found_reg <= 1'b0;
      lost_reg <= 1'b0;
      load_reg <= 1'b0;
      accept_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bitcnt_reg <= bitcnt_next;
      err_sum_reg <= err_sum_next;
      noedge_reg <= noedge_next;
      est_reg <= est_next;
      found_reg <= found_next;
      lost_reg <= lost_next;
      load_reg <= load_next;
      accept_reg <= accept_next;
    end
  end

  always_comb
  begin
    irq_events = '0;
    irq_events[IRQ_SYNC_FOUND] = found_next;
    irq_events[IRQ_SYNC_LOST] = lost_next;
    // a loss of sync in the same cycle takes the other branch: no reject then
    irq_events[IRQ_RATE_REJECT] = (state_reg == ST_START_VALUE_INTERVAL) && start_value_interval_done && rate_bad
                                  && !lost_next && !ACQ_START_IN;
    irq_events[IRQ_EDGE_VIOL] = edge_bad && (state_reg == ST_TRACK);
  end

  assign SYNC_FOUND_OUT = (state_reg == ST_TRACK);
  assign SYNC_LOST_OUT = lost_reg;
  assign EDGE_ACCEPT_OUT = accept_reg;
  assign INTEG_LOAD_OUT = load_reg;
  assign INTEG_VALUE_OUT = est_reg;

endmodule
`default_nettype wire

// ---- src/cdr_pkg.sv ----
package cdr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFF_START_VALUE_INTERVAL_CFG = 8'h48;
  localparam logic [7:0] OFF_CHIP_TOL = 8'h49;
  localparam logic [7:0] OFF_BIT_TOL = 8'h4a;
  localparam logic [7:0] OFF_WINDOW = 8'h4b;
  localparam logic [7:0] OFF_POS_LIMIT = 8'he0;
  localparam logic [7:0] OFF_NEG_LIMIT = 8'he1;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'he2;
  localparam logic [7:0] OFF_IRQ_MASK = 8'he3;
  localparam logic [7:0] OFF_LOOP_STATE = 8'he4;
  localparam logic [7:0] OFF_RATE_EST = 8'he5;

  // reset values
  localparam logic [7:0] RST_START_VALUE_INTERVAL_CFG = 8'h01;
  localparam logic [7:0] RST_CHIP_TOL = 8'h0c;
  localparam logic [7:0] RST_BIT_TOL = 8'h1e;
  localparam logic [7:0] RST_WINDOW = 8'h28;
  localparam logic [7:0] RST_POS_LIMIT = 8'h10;
  localparam logic [7:0] RST_NEG_LIMIT = 8'h10;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  // writable bits, everything else reads zero
  localparam logic [7:0] WMASK_START_VALUE_INTERVAL_CFG = 8'h07;
  localparam logic [7:0] WMASK_TOL = 8'h3f;
  localparam logic [7:0] WMASK_WINDOW = 8'hff;
  localparam logic [7:0] WMASK_IRQ = 8'h0f;

  // field positions
  localparam int LIMEN_BIT = 2;
  localparam int START_VALUE_INTERVAL_LENGTH_LSB = 0;
  localparam int START_VALUE_INTERVAL_LENGTH_W = 2;
  localparam int TOL_LATE_LSB = 3;
  localparam int TOL_EARLY_LSB = 0;
  localparam int TOL_W = 3;

  // interrupt status bits
  localparam int IRQ_SYNC_FOUND = 0;
  localparam int IRQ_SYNC_LOST = 1;
  localparam int IRQ_RATE_REJECT = 2;
  localparam int IRQ_EDGE_VIOL = 3;

  // phase resolution: sixteenths of a bit
  localparam int PHASE_W = 4;
  localparam logic [3:0] BIT_BORDER_PHASE = 4'h0;
  localparam logic [3:0] CHIP_BORDER_PHASE = 4'h8;
  localparam logic [3:0] LAST_PHASE = 4'hf;

  // run-in length in bits is 2**(START_VALUE_INTERVAL_SHIFT_BASE + start_value_interval_length)
  localparam int START_VALUE_INTERVAL_SHIFT_BASE = 3;
  localparam int BITCNT_W = 7;
  localparam int SUM_W = 13;
  localparam int EST_W = 9;
  localparam int NOEDGE_W = 9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START_VALUE_INTERVAL = 2'b01,
    ST_TRACK = 2'b10,
    ST_LOST = 2'b11
  } cdr_state_e;

endpackage

// ---- src/cdr_border_check.sv ----
`timescale 1ns/100ps
`default_nettype none
module cdr_border_check #(
  parameter int PHASE_W = 4,
  parameter int TOL_W = 3
) (
  input wire logic [PHASE_W-1:0] phase_in,
  input wire logic [PHASE_W-1:0] center_in,
  input wire logic [TOL_W-1:0] early_tol_in,
  input wire logic [TOL_W-1:0] late_tol_in,
  output logic hit_out
);

  logic [PHASE_W-1:0] late_dist;
  logic [PHASE_W-1:0] early_dist;

  // distances wrap modulo one bit period
  always_comb
  begin
    late_dist = phase_in - center_in;
    early_dist = center_in - phase_in;
    hit_out = (late_dist <= PHASE_W'(late_tol_in)) || (early_dist <= PHASE_W'(early_tol_in));
  end

endmodule
`default_nettype wire

// ---- test/cdr_start_value_interval_tol_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module cdr_start_value_interval_tol_assertions (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic SAMPLE_VALID_IN,
  input wire logic EDGE_IN,
  input wire logic SYNC_FOUND_OUT,
  input wire logic SYNC_LOST_OUT,
  input wire logic EDGE_ACCEPT_OUT,
  input wire logic INTEG_LOAD_OUT,
  input wire logic [8:0] INTEG_VALUE_OUT,
  input wire logic IRQ_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  ////////////////////////////////////////
  rd_idle_a: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
    else $error("read data not zero");
  start_value_interval_unused_a: assert property (REG_RD_IN && REG_ADDR_IN == 8'h48 |=> !(|REG_RDATA_OUT[7:3]))
    else $error("unused bits not zero");
  load_found_a: assert property (INTEG_LOAD_OUT |-> SYNC_FOUND_OUT)
    else $error("load without sync");
  load_pulse_a: assert property (INTEG_LOAD_OUT |=> !INTEG_LOAD_OUT)
    else $error("load pulse too long");
  found_cause_a: assert property ($rose(SYNC_FOUND_OUT) |-> INTEG_LOAD_OUT)
    else $error("sync found without load");
  accept_cause_a: assert property (EDGE_ACCEPT_OUT |-> $past(SAMPLE_VALID_IN) && $past(EDGE_IN))
    else $error("accept without edge");
  lost_pulse_a: assert property (SYNC_LOST_OUT |-> !SYNC_FOUND_OUT ##1 !SYNC_LOST_OUT)
    else $error("lost pulse wrong");
  value_hold_a: assert property (!INTEG_LOAD_OUT |-> $stable(INTEG_VALUE_OUT))
    else $error("estimate moved");
  load_c: cover property (INTEG_LOAD_OUT);
  lost_c: cover property (SYNC_LOST_OUT);
  irq_c: cover property (IRQ_OUT);
endmodule
bind cdr_start_value_interval_tol cdr_start_value_interval_tol_assertions u_chk (.REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .EDGE_IN(EDGE_IN), .SYNC_FOUND_OUT(SYNC_FOUND_OUT),
  .SYNC_LOST_OUT(SYNC_LOST_OUT), .EDGE_ACCEPT_OUT(EDGE_ACCEPT_OUT),
  .INTEG_LOAD_OUT(INTEG_LOAD_OUT), .INTEG_VALUE_OUT(INTEG_VALUE_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ---- test/cdr_demod_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module cdr_demod_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic acq_in,
  input wire logic run_in,
  input wire logic slow_in,
  input wire logic edge_en_in,
  input wire logic [3:0] edge_phase_in,
  output logic valid_out,
  output logic edge_out
);
  logic [3:0] ph_reg;
  logic [3:0] ph_next;
  logic valid_next;
  logic edge_next;
  always_comb
  begin
    ph_next = acq_in ? 4'h0 : ph_reg + {3'h0, valid_out};
    valid_next = run_in && !(slow_in && valid_out);
    // no sample: junk on the edge line so it is never trusted
    edge_next = valid_next ? edge_en_in && ph_next == edge_phase_in : !edge_out;
  end
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ph_reg <= 4'h0;
      valid_out <= 1'b0;
      edge_out <= 1'b0;
    end
    else
    begin
      ph_reg <= ph_next;
      valid_out <= valid_next;
      edge_out <= edge_next;
    end
  end
endmodule
`default_nettype wire

// ---- test/test_cdr_start_value_interval_tol.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_cdr_start_value_interval_tol;
  import cdr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic acq = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic een = 1'b1;
  logic [3:0] eph = 4'h0;
  logic valid, edg, found, lost, acc, load, irq;
  logic [7:0] rdata;
  logic [8:0] ival;
  logic [5:0] ctab [2] = '{6'h0a, 6'h13};
  logic [5:0] btab [2] = '{6'h19, 6'h0a};
  int failures = 0;
  int n_checks = 0;
  int scnt = 0;
  int gcnt = 0;
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    scnt <= acq ? 0 : scnt + int'(valid);
    gcnt <= (valid && edg) ? 0 : gcnt + int'(valid);
  end
  cdr_start_value_interval_tol dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .SAMPLE_VALID_IN(valid), .EDGE_IN(edg), .ACQ_START_IN(acq), .SYNC_FOUND_OUT(found),
    .SYNC_LOST_OUT(lost), .EDGE_ACCEPT_OUT(acc), .INTEG_LOAD_OUT(load),
    .INTEG_VALUE_OUT(ival), .IRQ_OUT(irq));
  cdr_demod_model u_demod (.clk_in(clk), .rstn_in(rstn), .acq_in(acq), .run_in(run),
    .slow_in(slow), .edge_en_in(een), .edge_phase_in(eph), .valid_out(valid), .edge_out(edg));
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x, input string m);
    n_checks++;
    if (g !== x)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // idle edge so a following write never reassigns the strobe in this step
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e}, "reg");
    @(posedge clk);
  endtask
  task automatic acquire();
    acq <= 1'b1;
    @(posedge clk);
    acq <= 1'b0;
  endtask
  task automatic halt();
    run <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // sel 0 load, 1 lost, 2 accept
  task automatic wt(input int sel, input int lim, input bit must, output bit hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(posedge clk);
      #1 hit = (sel == 0 ? load : sel == 1 ? lost : acc) === 1'b1;
    end
    if (must && !hit)
    begin
      failures++;
      $display("MISMATCH t=%0t wait ran out", $time);
      summarize();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rchk(OFF_START_VALUE_INTERVAL_CFG, 8'h01);
    rchk(OFF_CHIP_TOL, 8'h0c);
    rchk(OFF_BIT_TOL, 8'h1e);
    rchk(OFF_WINDOW, 8'h28);
    wreg(OFF_START_VALUE_INTERVAL_CFG, 8'hf8);
    rchk(OFF_START_VALUE_INTERVAL_CFG, 8'h00);
    wreg(OFF_CHIP_TOL, 8'hff);
    rchk(OFF_CHIP_TOL, 8'h3f);
    wreg(8'h50, 8'h55);
    rchk(8'h50, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_start_value_interval();
    bit hit;
    for (int len = 0; len < 4; len++)
    begin
      slow <= len[0];
      wreg(OFF_START_VALUE_INTERVAL_CFG, 8'(len));
      run <= 1'b1;
      acquire();
      wt(0, 2200, 1'b1, hit);
      chk(16'(scnt), 16'(16 << (3 + len)), "run-in");
      chk(16'(ival), 16'h0000, "estimate");
      chk(16'(found), 16'h0001, "found");
      halt();
    end
    slow <= 1'b0;
    $display("test run-in done");
  endtask
  task automatic t_rate();
    bit hit;
    for (int s = 0; s < 2; s++)
    begin
      eph <= s ? 4'he : 4'h2;
      wreg(s ? OFF_NEG_LIMIT : OFF_POS_LIMIT, 8'h01);
      wreg(OFF_IRQ_MASK, 8'h04);
      wreg(OFF_START_VALUE_INTERVAL_CFG, 8'h04);
      run <= 1'b1;
      acquire();
      wt(0, 300, 1'b0, hit);
      chk(16'(hit), 16'h0000, "limited load");
      chk(16'(irq), 16'h0001, "reject irq");
      halt();
      wreg(OFF_IRQ_MASK, 8'h00);
      #1 chk(16'(irq), 16'h0000, "masked irq");
      wreg(OFF_IRQ_STATUS, 8'h0f);
      wreg(OFF_IRQ_MASK, 8'h0f);
      #1 chk(16'(irq), 16'h0000, "cleared irq");
      wreg(OFF_START_VALUE_INTERVAL_CFG, 8'h00);
      run <= 1'b1;
      acquire();
      wt(0, 200, 1'b1, hit);
      chk(16'(ival), s ? 16'h01fe : 16'h0002, "estimate");
      halt();
      wreg(OFF_IRQ_STATUS, 8'h0f);
      wreg(s ? OFF_NEG_LIMIT : OFF_POS_LIMIT, 8'h10);
    end
    $display("test rate done");
  endtask
  task automatic t_tol();
    bit hit;
    logic [3:0] p;
    logic e;
    for (int k = 0; k < 2; k++)
    begin
      wreg(OFF_CHIP_TOL, {2'b00, ctab[k]});
      wreg(OFF_BIT_TOL, {2'b00, btab[k]});
      for (int i = 0; i < 16; i++)
      begin
        p = i[3:0];
        e = (p - 4'h8) <= ctab[k][5:3] || (4'h8 - p) <= ctab[k][2:0] ||
          p <= btab[k][5:3] || (4'h0 - p) <= btab[k][2:0];
        eph <= p;
        run <= 1'b1;
        acquire();
        wt(2, 20, 1'b0, hit);
        chk(16'(hit), 16'(e), "accept");
        halt();
      end
    end
    $display("test tolerance done");
  endtask
  task automatic t_window();
    bit hit;
    eph <= 4'h0;
    for (int w = 0; w < 2; w++)
    begin
      // smaller than default on the first pass, larger on the second
      wreg(OFF_WINDOW, w ? 8'h30 : 8'h14);
      run <= 1'b1;
      acquire();
      wt(0, 200, 1'b1, hit);
      een <= 1'b0;
      wt(1, 100, 1'b1, hit);
      chk(16'(gcnt), w ? 16'd49 : 16'd21, "edgeless");
      chk(16'(found), 16'h0000, "found");
      rchk(OFF_IRQ_STATUS, 8'h03);
      een <= 1'b1;
      halt();
    end
    $display("test window done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_start_value_interval();
    t_rate();
    t_tol();
    t_window();
    summarize();
  end
endmodule
`default_nettype wire
